// [src/wfp_pkg.sv]
// Package: register map, field layout and types of the wake-frame power-capability block
package wfp_pkg;

  // ---------------------------------------------------------------
  // Register map: bank base plus four times the register index
  // ---------------------------------------------------------------
  localparam logic [11:0] BANK_CTRL_BASE  = 12'h000;
  localparam logic [11:0] BANK_FRAME_BASE = 12'h100;
  localparam logic [11:0] IDX_POWER_CAPS  = 12'h008;
  localparam logic [11:0] IDX_WAKE_CTRL   = 12'h00a;
  localparam logic [11:0] IDX_POWER_CTRL  = 12'h00c;
  localparam logic [11:0] IDX_WAKE_STAT   = 12'h00e;
  localparam logic [11:0] IDX_CRC_LOW     = 12'h000;
  localparam logic [11:0] IDX_CRC_HIGH    = 12'h002;
  localparam logic [11:0] IDX_MASK0       = 12'h004;
  localparam logic [11:0] IDX_MASK1       = 12'h006;
  localparam logic [11:0] IDX_MASK2       = 12'h008;
  localparam logic [11:0] IDX_MASK3       = 12'h00a;
  localparam logic [11:0] ADDR_POWER_CAPS = BANK_CTRL_BASE + {IDX_POWER_CAPS[9:0], 2'b00};
  localparam logic [11:0] ADDR_WAKE_CTRL  = BANK_CTRL_BASE + {IDX_WAKE_CTRL[9:0], 2'b00};
  localparam logic [11:0] ADDR_POWER_CTRL = BANK_CTRL_BASE + {IDX_POWER_CTRL[9:0], 2'b00};
  localparam logic [11:0] ADDR_WAKE_STAT  = BANK_CTRL_BASE + {IDX_WAKE_STAT[9:0], 2'b00};
  localparam logic [11:0] ADDR_CRC_LOW    = BANK_FRAME_BASE + {IDX_CRC_LOW[9:0], 2'b00};
  localparam logic [11:0] ADDR_CRC_HIGH   = BANK_FRAME_BASE + {IDX_CRC_HIGH[9:0], 2'b00};
  localparam logic [11:0] ADDR_MASK0      = BANK_FRAME_BASE + {IDX_MASK0[9:0], 2'b00};
  localparam logic [11:0] ADDR_MASK1      = BANK_FRAME_BASE + {IDX_MASK1[9:0], 2'b00};
  localparam logic [11:0] ADDR_MASK2      = BANK_FRAME_BASE + {IDX_MASK2[9:0], 2'b00};
  localparam logic [11:0] ADDR_MASK3      = BANK_FRAME_BASE + {IDX_MASK3[9:0], 2'b00};

  // ---------------------------------------------------------------
  // Capability bit positions and configuration word layout
  // ---------------------------------------------------------------
  localparam int CAP_WAKE_D3COLD  = 15;
  localparam int CAP_WAKE_D3HOT   = 14;
  localparam int CAP_WAKE_D2      = 13;
  localparam int CAP_WAKE_D1      = 12;
  localparam int CAP_WAKE_D0      = 11;
  localparam int CAP_STATE2_SUP   = 10;
  localparam int CAP_STATE1_SUP   = 9;
  localparam int CAP_BUS_WIDE     = 0;
  localparam int CFG_WAKE_STATE2  = 5;
  localparam int CFG_WAKE_STATE1  = 4;
  localparam int CFG_STATE2_SUP   = 3;
  localparam int CFG_STATE1_SUP   = 2;
  localparam int CFG_NARROW_BUS   = 0;
  localparam logic [15:0] CAPS_RESET = 16'h4000;

  // ---------------------------------------------------------------
  // Control fields and reset values
  // ---------------------------------------------------------------
  localparam int CTL_MAGIC_EN     = 7;
  localparam logic [15:0] WAKE_CTRL_MASK  = 16'h008f;
  localparam logic [15:0] WAKE_CTRL_RESET = 16'h0000;
  localparam int PCS_WAKE_EN      = 8;
  localparam logic [15:0] POWER_CTRL_MASK  = 16'h0103;
  localparam logic [15:0] POWER_CTRL_RESET = 16'h0000;
  localparam logic [15:0] FRAME_REG_RESET  = 16'h0000;
  localparam int STAT_FRAME0      = 0;
  localparam logic [1:0] PSTATE_D0 = 2'h0;
  localparam logic [1:0] PSTATE_D1 = 2'h1;
  localparam logic [1:0] PSTATE_D2 = 2'h2;
  localparam logic [1:0] PSTATE_D3 = 2'h3;

  // ---------------------------------------------------------------
  // Pattern CRC
  // ---------------------------------------------------------------
  localparam logic [31:0] CRC_POLY   = 32'hedb88320;
  localparam logic [31:0] CRC_INIT   = 32'hffffffff;
  localparam logic [6:0]  PATTERN_LEN = 7'h40;

  typedef enum logic [1:0] {
    WFP_IDLE  = 2'b00,
    WFP_RECV  = 2'b01,
    WFP_CHECK = 2'b11
  } wfp_frame_e;

  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic [7:0] data;
  } wfp_rx_byte_s;

  typedef struct packed {
    logic [15:0] word;
    logic        valid;
  } wfp_cfg_word_s;

  function automatic logic [31:0] wfp_crc_byte(input logic [31:0] crc_in,
                                               input logic [7:0]  byte_in);
    logic [31:0] r;
    r = crc_in ^ {24'h000000, byte_in};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : wfp_crc_byte

endpackage : wfp_pkg

// [src/wfp_wake_frame_power_caps.sv]
// Wake-frame power-capability register bank with AHB-Lite slave and frame 0 detector
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps

module wfp_wake_frame_power_caps #(
  parameter bit WIDE_VARIANT = 1'b1
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 srst_i,
  // AHB-Lite slave
  input  wire logic                 hsel_i,
  input  wire logic [11:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic      [31:0]          hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  // Configuration memory
  input  wire logic                 cfg_memory_enable_i,
  input  wire wfp_pkg::wfp_cfg_word_s cfg_word_i,
  // Received byte stream
  input  wire wfp_pkg::wfp_rx_byte_s  rx_byte_i,
  // Detector enables and wake output
  output logic                      magic_packet_detect_en_o,
  output logic      [3:1]           frame_detect_en_o,
  output logic                      frame0_wake_o,
  output logic                      wake_event_out_n_o
);
  import wfp_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0] power_capabilities;
  logic [15:0] wake_frame_control;
  logic [15:0] power_control_status;
  logic [15:0] wake_status;
  logic [15:0] wake_frame0_crc_low;
  logic [15:0] wake_frame0_crc_high;
  logic [15:0] wake_frame0_mask_word0;
  logic [15:0] wake_frame0_mask_word1;
  logic [15:0] wake_frame0_mask_word2;
  logic [15:0] wake_frame0_mask_word3;
  logic        wr_pend;
  logic [11:0] wr_addr;
  logic [31:0] rd_data;
  wfp_frame_e  frame_state;
  wfp_frame_e  next_frame_state;
  logic [31:0] crc;
  logic [6:0]  byte_cnt;
  logic        wake_out_n;
  logic        frame0_hit;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire         addr_phase = hsel_i & htrans_i[1] & hready_i;
  wire         rd_req     = addr_phase & ~hwrite_i;
  wire         wr_req     = addr_phase & hwrite_i;
  wire  [15:0] wdata      = hwdata_i[15:0];
  wire         wr_caps    = wr_pend & (wr_addr == ADDR_POWER_CAPS);
  wire         wr_ctrl    = wr_pend & (wr_addr == ADDR_WAKE_CTRL);
  wire         wr_pcs     = wr_pend & (wr_addr == ADDR_POWER_CTRL);
  wire         wr_stat    = wr_pend & (wr_addr == ADDR_WAKE_STAT);
  wire         wr_crc_lo  = wr_pend & (wr_addr == ADDR_CRC_LOW);
  wire         wr_crc_hi  = wr_pend & (wr_addr == ADDR_CRC_HIGH);
  wire         wr_mask0   = wr_pend & (wr_addr == ADDR_MASK0);
  wire         wr_mask1   = wr_pend & (wr_addr == ADDR_MASK1);
  wire         wr_mask2   = wr_pend & (wr_addr == ADDR_MASK2);
  wire         wr_mask3   = wr_pend & (wr_addr == ADDR_MASK3);
  logic [15:0] rd_mux;

  always_comb begin
    if (haddr_i == ADDR_POWER_CAPS) begin
      rd_mux = power_capabilities;
    end else if (haddr_i == ADDR_WAKE_CTRL) begin
      rd_mux = wake_frame_control & WAKE_CTRL_MASK;
    end else if (haddr_i == ADDR_POWER_CTRL) begin
      rd_mux = power_control_status;
    end else if (haddr_i == ADDR_WAKE_STAT) begin
      rd_mux = wake_status;
    end else if (haddr_i == ADDR_CRC_LOW) begin
      rd_mux = wake_frame0_crc_low;
    end else if (haddr_i == ADDR_CRC_HIGH) begin
      rd_mux = wake_frame0_crc_high;
    end else if (haddr_i == ADDR_MASK0) begin
      rd_mux = wake_frame0_mask_word0;
    end else if (haddr_i == ADDR_MASK1) begin
      rd_mux = wake_frame0_mask_word1;
    end else if (haddr_i == ADDR_MASK2) begin
      rd_mux = wake_frame0_mask_word2;
    end else if (haddr_i == ADDR_MASK3) begin
      rd_mux = wake_frame0_mask_word3;
    end else begin
      rd_mux = 16'h0000;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      rd_data <= 32'h00000000;
    end else begin
      wr_pend <= wr_req;
      wr_addr <= haddr_i;
      if (rd_req) begin
        rd_data <= {16'h0000, rd_mux};
      end
    end
  end

  assign hrdata_o    = rd_data;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // ---------------------------------------------------------------
  // Capability register
  // ---------------------------------------------------------------
  wire         cfg_load = cfg_word_i.valid & cfg_memory_enable_i;
  logic [15:0] next_caps;

  always_comb begin
    next_caps = CAPS_RESET;
    next_caps[CAP_WAKE_D2]    = cfg_word_i.word[CFG_WAKE_STATE2];
    next_caps[CAP_WAKE_D1]    = cfg_word_i.word[CFG_WAKE_STATE1];
    next_caps[CAP_STATE2_SUP] = cfg_word_i.word[CFG_STATE2_SUP];
    next_caps[CAP_STATE1_SUP] = cfg_word_i.word[CFG_STATE1_SUP];
    next_caps[CAP_BUS_WIDE]   = WIDE_VARIANT & ~cfg_word_i.word[CFG_NARROW_BUS];
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      power_capabilities <= CAPS_RESET;
    end else if (cfg_load) begin
      power_capabilities <= next_caps;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wake_frame_control   <= WAKE_CTRL_RESET;
      power_control_status <= POWER_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        wake_frame_control <= wdata & WAKE_CTRL_MASK;
      end
      if (wr_pcs) begin
        power_control_status <= wdata & POWER_CTRL_MASK;
      end
    end
  end

  assign magic_packet_detect_en_o = wake_frame_control[CTL_MAGIC_EN];
  assign frame_detect_en_o        = wake_frame_control[3:1];

  // ---------------------------------------------------------------
  // Frame 0 pattern registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wake_frame0_crc_low    <= FRAME_REG_RESET;
      wake_frame0_crc_high   <= FRAME_REG_RESET;
      wake_frame0_mask_word0 <= FRAME_REG_RESET;
      wake_frame0_mask_word1 <= FRAME_REG_RESET;
      wake_frame0_mask_word2 <= FRAME_REG_RESET;
      wake_frame0_mask_word3 <= FRAME_REG_RESET;
    end else begin
      if (wr_crc_lo) begin
        wake_frame0_crc_low <= wdata;
      end
      if (wr_crc_hi) begin
        wake_frame0_crc_high <= wdata;
      end
      if (wr_mask0) begin
        wake_frame0_mask_word0 <= wdata;
      end
      if (wr_mask1) begin
        wake_frame0_mask_word1 <= wdata;
      end
      if (wr_mask2) begin
        wake_frame0_mask_word2 <= wdata;
      end
      if (wr_mask3) begin
        wake_frame0_mask_word3 <= wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Frame 0 pattern detector
  // ---------------------------------------------------------------
  wire  [63:0] mask_all  = {wake_frame0_mask_word3, wake_frame0_mask_word2,
                            wake_frame0_mask_word1, wake_frame0_mask_word0};
  wire  [31:0] expect_crc = {wake_frame0_crc_high, wake_frame0_crc_low};
  wire         start_byte = (frame_state == WFP_IDLE) & rx_byte_i.valid & rx_byte_i.sof;
  wire         take_byte  = start_byte | ((frame_state == WFP_RECV) & rx_byte_i.valid);
  wire  [6:0]  byte_idx   = start_byte ? 7'h00 : byte_cnt;
  wire         in_window  = byte_idx < PATTERN_LEN;
  wire         sel_byte   = take_byte & in_window & mask_all[byte_idx[5:0]];
  wire  [31:0] crc_base   = start_byte ? CRC_INIT : crc;
  wire  [31:0] next_crc   = sel_byte ? wfp_crc_byte(crc_base, rx_byte_i.data) : crc_base;
  wire         crc_match  = ~crc == expect_crc;
  assign frame0_hit = (frame_state == WFP_CHECK) & wake_frame_control[0] & crc_match;

  always_comb begin
    case (frame_state)
      WFP_IDLE: begin
        if (start_byte) begin
          next_frame_state = rx_byte_i.eof ? WFP_CHECK : WFP_RECV;
        end else begin
          next_frame_state = WFP_IDLE;
        end
      end
      WFP_RECV: begin
        if (rx_byte_i.valid & rx_byte_i.eof) begin
          next_frame_state = WFP_CHECK;
        end else begin
          next_frame_state = WFP_RECV;
        end
      end
      WFP_CHECK: begin
        next_frame_state = WFP_IDLE;
      end
      default: begin
        next_frame_state = WFP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      frame_state <= WFP_IDLE;
      crc         <= CRC_INIT;
      byte_cnt    <= 7'h00;
    end else begin
      frame_state <= next_frame_state;
      crc         <= next_crc;
      if (take_byte & in_window) begin
        byte_cnt <= byte_idx + 7'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Wake status and wake output
  // ---------------------------------------------------------------
  wire [1:0] pstate   = power_control_status[1:0];
  wire       wake_en  = power_control_status[PCS_WAKE_EN];
  wire       state_ok = ((pstate == PSTATE_D3) & power_capabilities[CAP_WAKE_D3HOT])
                      | ((pstate == PSTATE_D2) & power_capabilities[CAP_WAKE_D2])
                      | ((pstate == PSTATE_D1) & power_capabilities[CAP_WAKE_D1])
                      | ((pstate == PSTATE_D0) & power_capabilities[CAP_WAKE_D0]);
  wire       stat_clr = wr_stat & wdata[STAT_FRAME0];

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wake_status <= 16'h0000;
      wake_out_n  <= 1'b1;
    end else begin
      if (frame0_hit) begin
        wake_status[STAT_FRAME0] <= 1'b1;
      end else if (stat_clr) begin
        wake_status[STAT_FRAME0] <= 1'b0;
      end
      wake_out_n <= ~(wake_status[STAT_FRAME0] & wake_en & state_ok);
    end
  end

  assign frame0_wake_o      = wake_status[STAT_FRAME0];
  assign wake_event_out_n_o = wake_out_n;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  property p_cold_zero;
    power_capabilities[CAP_WAKE_D3COLD] == 1'b0 && power_capabilities[CAP_WAKE_D0] == 1'b0;
  endproperty
  a_cold_zero: assert property (p_cold_zero) else $error("cold or D0 wake bit set");

  property p_hot_one;
    power_capabilities[CAP_WAKE_D3HOT];
  endproperty
  a_hot_one: assert property (p_hot_one) else $error("hot D3 wake bit clear");

  property p_cfg_load;
    cfg_load |=> power_capabilities[CAP_WAKE_D2] == $past(cfg_word_i.word[CFG_WAKE_STATE2])
              && power_capabilities[CAP_STATE1_SUP] == $past(cfg_word_i.word[CFG_STATE1_SUP]);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config word not loaded");

  property p_no_mem_default;
    !cfg_load && $past(!cfg_load) |-> power_capabilities == $past(power_capabilities);
  endproperty
  a_no_mem_default: assert property (p_no_mem_default) else $error("caps changed w/o load");

  property p_d0_silent;
    pstate == PSTATE_D0 |=> wake_event_out_n_o;
  endproperty
  a_d0_silent: assert property (p_d0_silent) else $error("wake output asserted in D0");

  property p_d2_gate;
    pstate == PSTATE_D2 && !power_capabilities[CAP_WAKE_D2] |=> wake_event_out_n_o;
  endproperty
  a_d2_gate: assert property (p_d2_gate) else $error("wake output in D2 unsupported");

  property p_d1_wake;
    pstate == PSTATE_D1 && power_capabilities[CAP_WAKE_D1] && wake_en
      && wake_status[STAT_FRAME0] |=> !wake_event_out_n_o;
  endproperty
  a_d1_wake: assert property (p_d1_wake) else $error("wake output missing in D1");

  property p_ctrl_reserved;
    (wake_frame_control & ~WAKE_CTRL_MASK) == 16'h0000;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved control bit set");

  property p_ctrl_write;
    wr_ctrl |=> wake_frame_control[CTL_MAGIC_EN] == $past(wdata[CTL_MAGIC_EN])
             && frame_detect_en_o == $past(wdata[3:1]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_hit_flags;
    frame0_hit |=> frame0_wake_o;
  endproperty
  a_hit_flags: assert property (p_hit_flags) else $error("frame 0 match not flagged");

  property p_disabled_quiet;
    !wake_frame_control[0] && !frame0_wake_o |=> !frame0_wake_o;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("flag set while disabled");

  property p_window_skip;
    take_byte && !in_window |=> crc == $past(crc);
  endproperty
  a_window_skip: assert property (p_window_skip) else $error("byte past 64 used in CRC");

  property p_mask_skip;
    frame_state == WFP_RECV && take_byte && !mask_all[byte_idx[5:0]] |=> crc == $past(crc);
  endproperty
  a_mask_skip: assert property (p_mask_skip) else $error("unmasked byte used in CRC");

  property p_read_data;
    rd_req && haddr_i == ADDR_CRC_HIGH |=> hrdata_o == {16'h0000, $past(wake_frame0_crc_high)};
  endproperty
  a_read_data: assert property (p_read_data) else $error("crc high read mismatch");

  property p_caps_write;
    wr_caps && !cfg_load |=> power_capabilities == $past(power_capabilities);
  endproperty
  a_caps_write: assert property (p_caps_write) else $error("capability write took effect");

  c_frame_hit:  cover property (frame0_hit);
  c_wake_d3:    cover property (pstate == PSTATE_D3 ##1 !wake_event_out_n_o);
  c_cfg_load:   cover property (cfg_load);
  c_long_frame: cover property (take_byte && !in_window);

endmodule : wfp_wake_frame_power_caps

// [bench/wfp_host_model.sv]
// Host model: AHB-Lite master issuing single word transfers
`timescale 1ns/100ps

module wfp_host_model (
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic [11:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  initial begin
    hsel_o = 1'b1;
    haddr_o = 12'h000;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h00000000;
  end

  // Address phase held until hready, then data phase held until hready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    haddr_o <= a;
    hwrite_o <= w;
    htrans_o <= 2'h2;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'h0;
    hwdata_o <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    q = hrdata_i;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h00000000, q);
  endtask : rd
endmodule : wfp_host_model

// [bench/wfp_wake_frame_power_caps_tb.sv]
// Testbench: register access, configuration load, frame match and wake output
`timescale 1ns/100ps

module wfp_wake_frame_power_caps_tb;
  import wfp_pkg::*;
  logic sys_clk, srst, hsel, hwrite, hready, hresp, cfg_en, magic_en, f0_wake, wake_n;
  logic c13, c12, e;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, fr_en;
  logic [31:0] hwdata, hrdata, rd, c;
  logic [63:0] m;
  wfp_cfg_word_s cfg;
  wfp_rx_byte_s rx;
  int bad_count = 0;
  int n_compared = 0;

  wfp_wake_frame_power_caps uut (.sys_clk_i(sys_clk), .srst_i(srst), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .cfg_memory_enable_i(cfg_en), .cfg_word_i(cfg), .rx_byte_i(rx),
    .magic_packet_detect_en_o(magic_en), .frame_detect_en_o(fr_en),
    .frame0_wake_o(f0_wake), .wake_event_out_n_o(wake_n));
  wfp_host_model host (.clk_i(sys_clk), .hready_i(hready), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hsize_o(hsize), .hwdata_o(hwdata));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    host.rd(a, rd);
    chk(rd, exp);
  endtask : rdchk

  task automatic load(input logic [15:0] w);
    @(posedge sys_clk) cfg <= '{w, 1'b1};
    @(posedge sys_clk) cfg <= '{w, 1'b0};
    @(posedge sys_clk);
  endtask : load

  task automatic send(input int n);
    for (int i = 1; i <= n; i++) begin
      @(posedge sys_clk) rx <= '{1'b1, i == 1, i == n, 8'(i)};
    end
    @(posedge sys_clk) rx <= '0;
    repeat (4) @(posedge sys_clk);
  endtask : send

  task automatic states;
    for (int s = 0; s < 4; s++) begin
      host.wr(ADDR_POWER_CTRL, 32'h100 | 32'(s));
      repeat (3) @(posedge sys_clk);
      e = !(s == 3 || (s == 2 && c13) || (s == 1 && c12));
      chk(32'(wake_n), 32'(e));
    end
  endtask : states

  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    close_out;
  end

  initial begin
    srst = 1'b1;
    cfg_en = 1'b0;
    cfg = '0;
    rx = '0;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    rdchk(ADDR_POWER_CAPS, 32'h4000);
    rdchk(ADDR_WAKE_CTRL, 32'h0);
    rdchk(ADDR_CRC_HIGH, 32'h0);
    host.wr(ADDR_POWER_CAPS, 32'hffff);
    rdchk(ADDR_POWER_CAPS, 32'h4000);
    load(16'h003c);
    rdchk(ADDR_POWER_CAPS, 32'h4000);
    cfg_en <= 1'b1;
    load(16'h003c);
    rdchk(ADDR_POWER_CAPS, 32'h7601);
    c13 = 1'b1;
    c12 = 1'b1;
    host.wr(ADDR_WAKE_CTRL, 32'hffff);
    rdchk(ADDR_WAKE_CTRL, 32'h8f);
    chk(32'({magic_en, fr_en}), 32'hf);
    host.wr(ADDR_MASK0, 32'h0001);
    host.wr(ADDR_MASK1, 32'h8000);
    host.wr(ADDR_MASK2, 32'h0001);
    host.wr(ADDR_MASK3, 32'h8000);
    m = {16'h8000, 16'h0001, 16'h8000, 16'h0001};
    c = 32'hffffffff;
    for (int i = 1; i <= 64; i++) begin
      if (m[i-1]) begin
        c = c ^ 32'(i);
        repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
    end
    c = ~c;
    host.wr(ADDR_CRC_LOW, {16'h0, c[15:0]});
    host.wr(ADDR_CRC_HIGH, {16'h0, c[31:16]});
    rdchk(ADDR_CRC_LOW, {16'h0, c[15:0]});
    send(66);
    chk(32'(f0_wake), 32'h1);
    states();
    host.wr(ADDR_POWER_CTRL, 32'h0003);
    repeat (3) @(posedge sys_clk);
    chk(32'(wake_n), 32'h1);
    load(16'h0001);
    rdchk(ADDR_POWER_CAPS, 32'h4000);
    c13 = 1'b0;
    c12 = 1'b0;
    states();
    host.wr(ADDR_WAKE_STAT, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(32'(f0_wake), 32'h0);
    host.wr(ADDR_MASK3, 32'h4000);
    send(66);
    chk(32'(f0_wake), 32'h0);
    rdchk(12'h0f0, 32'h0);
    chk(32'(hresp), 32'h0);
    host.wr(ADDR_MASK3, 32'h8000);
    host.wr(ADDR_WAKE_CTRL, 32'h008e);
    send(66);
    chk(32'(f0_wake), 32'h0);
    chk(32'({magic_en, fr_en}), 32'hf);
    close_out;
  end
endmodule : wfp_wake_frame_power_caps_tb
